// file: logic/psi_pkg.sv
package psi_pkg;

	// ----------------------------------------------------------------
	// widths and sizes
	// ----------------------------------------------------------------
	localparam int PC_W        = 9;
	localparam int STACK_W     = 12;
	localparam int STACK_DEPTH = 4;
	localparam int DMEM_DEPTH  = 32;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [8:0] PC_RESET    = 9'h1FF;
	localparam logic [1:0] PAGE_RESET  = 2'h0;
	localparam logic [7:0] ACC_RESET   = 8'h00;
	localparam logic [4:0] PTR_RESET   = 5'h00;
	localparam logic [2:0] PTR_UNIMPL  = 3'h7;
	localparam logic [7:0] RES_RESET   = 8'h00;
	localparam logic [11:0] INSTR_RESET = 12'h000;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_EXEC    = 8'h00;
	localparam logic [7:0] OFF_PC      = 8'h04;
	localparam logic [7:0] OFF_ACC     = 8'h08;
	localparam logic [7:0] OFF_STATUS  = 8'h0C;
	localparam logic [7:0] OFF_CTRL    = 8'h10;
	localparam logic [7:0] OFF_POINTER = 8'h14;
	localparam logic [7:0] OFF_STACK   = 8'h18;
	localparam logic [7:0] OFF_WINDOW  = 8'h80;

	// ----------------------------------------------------------------
	// data file addresses, opcodes, responses
	// ----------------------------------------------------------------
	localparam logic [4:0] IND_PORT_ADDR = 5'h00;
	localparam logic [4:0] LOW_BYTE_ADDR = 5'h02;
	localparam logic [2:0] OPC_GOTO      = 3'h5;
	localparam logic [3:0] OPC_CALL      = 4'h9;
	localparam logic [3:0] OPC_RETURN    = 4'h8;
	localparam logic [2:0] OPC_BITOP     = 3'h2;
	localparam logic [1:0] OPC_FILE      = 2'h0;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_EXEC  = 3'b010,
		ST_FLUSH = 3'b100
	} psi_state_t;

	// ----------------------------------------------------------------
	// shared functions
	// ----------------------------------------------------------------
	function automatic logic [8:0] psi_pc_inc(input logic [8:0] pc);
		return pc + 9'h001;
	endfunction : psi_pc_inc

	function automatic logic psi_mapped(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a[7] || (a <= OFF_STACK));
	endfunction : psi_mapped

	function automatic logic [4:0] psi_eff(input logic [7:0] a,
		input logic [4:0] ptr);
		return (a[6:2] == IND_PORT_ADDR) ? ptr : a[6:2];
	endfunction : psi_eff

endpackage : psi_pkg

// file: logic/psi_ifs.sv
`timescale 1ns/1ps
interface psi_stack_if;
	logic        push;
	logic        pop;
	logic [11:0] push_data;
	logic [11:0] top;
	modport ctrl  (output push, output pop, output push_data, input top);
	modport store (input push, input pop, input push_data, output top);
endinterface : psi_stack_if

interface psi_mem_if;
	logic       we;
	logic [4:0] waddr;
	logic [7:0] wdata;
	logic [4:0] raddr;
	logic [7:0] rdata;
	modport ctrl (output we, output waddr, output wdata, output raddr,
		input rdata);
	modport mem  (input we, input waddr, input wdata, input raddr,
		output rdata);
endinterface : psi_mem_if

// file: logic/psi_stack.sv
`timescale 1ns/1ps
module psi_stack import psi_pkg::*; (
	// clock
	input wire logic   i_clk,
	// stack port
	psi_stack_if.store stk
);

	logic [STACK_DEPTH-1:0][STACK_W-1:0] lvl_reg;
	logic [STACK_DEPTH-1:0][STACK_W-1:0] lvl_next;

	always_comb begin
		lvl_next = lvl_reg;
		if (stk.push) begin
			// oldest level falls off the bottom, silently
			for (int i = STACK_DEPTH - 1; i > 0; i--) begin
				lvl_next[i] = lvl_reg[i-1];
			end
			lvl_next[0] = stk.push_data;
		end else if (stk.pop) begin
			// deepest level keeps its value on underflow
			for (int i = 0; i < STACK_DEPTH - 1; i++) begin
				lvl_next[i] = lvl_reg[i+1];
			end
		end
	end

	// no reset on purpose: return addresses survive every reset
	always_ff @(posedge i_clk) begin
		lvl_reg <= lvl_next;
	end

	assign stk.top = lvl_reg[0];

endmodule : psi_stack

// file: logic/psi_dmem.sv
`timescale 1ns/1ps
module psi_dmem import psi_pkg::*; (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// memory port
	psi_mem_if.mem   m
);

	logic [7:0] mem_reg [DMEM_DEPTH];
	logic [7:0] rdata_reg;

	always_ff @(posedge i_clk) begin
		if (m.we) begin
			mem_reg[m.waddr] <= m.wdata;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= mem_reg[m.raddr];
		end
	end

	assign m.rdata = rdata_reg;

endmodule : psi_dmem

// file: logic/psi_top.sv
`timescale 1ns/1ps
// Functional notes
// - counter advances by one per instruction unless it is loaded
// - absolute jump loads all nine counter bits from the instruction
// - call or low-byte write loads bits 7..0, bit 8 forced to zero
// - writes to the low counter byte act as computed jumps
// - reset sets the counter to the reset vector
// - reset clears the page select bits
// - four-level last-in-first-out return stack, twelve bits per level
// - over four nested calls keeps only the newest four addresses
// - underflow leaves level four unchanged so it fills upward
// - return also writes its literal into the accumulator
// - reset never alters the stack levels
// - no overflow or underflow indication exists
// - indirect port redirects to the data register the pointer names
// - pointer at the indirect port itself reads zero
// - pointer at the indirect port itself makes a write store nothing
// - pointer holds five bits selecting data addresses 00h to 1Fh
// - pointer bits 7 to 5 are unimplemented and read as ones
// - nine-bit counter, 512 words, wraps above the range
// - reset vector 1FFh, next sequential address is 000h
// - branches take two cycles, other instructions one
module psi_top import psi_pkg::*; (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	// write address channel
	input  wire logic        i_awvalid,
	output      logic        o_awready,
	input  wire logic [7:0]  i_awaddr,
	// write data channel
	input  wire logic        i_wvalid,
	output      logic        o_wready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	// write response channel
	output      logic        o_bvalid,
	input  wire logic        i_bready,
	output      logic [1:0]  o_bresp,
	// read address channel
	input  wire logic        i_arvalid,
	output      logic        o_arready,
	input  wire logic [7:0]  i_araddr,
	// read data channel
	output      logic        o_rvalid,
	input  wire logic        i_rready,
	output      logic [31:0] o_rdata,
	output      logic [1:0]  o_rresp
);

	// ----------------------------------------------------------------
	// sub-blocks
	// ----------------------------------------------------------------
	psi_stack_if stk_if ();
	psi_mem_if   mem_if ();

	psi_stack u_stack (
		.i_clk (i_clk),
		.stk   (stk_if.store)
	);

	psi_dmem u_dmem (
		.i_clk   (i_clk),
		.i_rst_b (i_rst_b),
		.m       (mem_if.mem)
	);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic        awready_reg;
	logic        awready_next;
	logic        wready_reg;
	logic        wready_next;
	logic        aw_have_reg;
	logic        aw_have_next;
	logic        w_have_reg;
	logic        w_have_next;
	logic [7:0]  awaddr_reg;
	logic [7:0]  awaddr_next;
	logic [31:0] wdata_reg;
	logic [31:0] wdata_next;
	logic [3:0]  wstrb_reg;
	logic [3:0]  wstrb_next;
	logic        bvalid_reg;
	logic        bvalid_next;
	logic [1:0]  bresp_reg;
	logic [1:0]  bresp_next;

	logic        arready_reg;
	logic        arready_next;
	logic        rpend_reg;
	logic        rpend_next;
	logic [7:0]  raddr_reg;
	logic [7:0]  raddr_next;
	logic        rzero_reg;
	logic        rzero_next;
	logic        rvalid_reg;
	logic        rvalid_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [1:0]  rresp_reg;
	logic [1:0]  rresp_next;
	logic [31:0] rd_word;

	psi_state_t  state_reg;
	psi_state_t  state_next;
	logic [8:0]  pc_reg;
	logic [8:0]  pc_next;
	logic [7:0]  acc_reg;
	logic [7:0]  acc_next;
	logic [1:0]  page_reg;
	logic [1:0]  page_next;
	logic [4:0]  ptr_reg;
	logic [4:0]  ptr_next;
	logic [11:0] instr_reg;
	logic [11:0] instr_next;
	logic [7:0]  result_reg;
	logic [7:0]  result_next;

	logic        busy;
	logic        do_write;
	logic        wr_err;
	logic        ar_fire;
	logic [4:0]  w_eff;
	logic        is_goto;
	logic        is_call;
	logic        is_ret;
	logic        is_low;

	// ----------------------------------------------------------------
	// write channels
	// ----------------------------------------------------------------
	assign busy     = (state_reg != ST_IDLE);
	assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;
	// an instruction issued while one is in flight is refused
	assign wr_err   = !psi_mapped(awaddr_reg) ||
		((awaddr_reg == OFF_EXEC) && busy);

	always_comb begin
		aw_have_next = aw_have_reg;
		w_have_next  = w_have_reg;
		awaddr_next  = awaddr_reg;
		wdata_next   = wdata_reg;
		wstrb_next   = wstrb_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		if (i_awvalid && awready_reg) begin
			aw_have_next = 1'b1;
			awaddr_next  = i_awaddr;
		end
		if (i_wvalid && wready_reg) begin
			w_have_next = 1'b1;
			wdata_next  = i_wdata;
			wstrb_next  = i_wstrb;
		end
		if (do_write) begin
			aw_have_next = 1'b0;
			w_have_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = wr_err ? RESP_SLVERR : RESP_OKAY;
		end
		if (bvalid_reg && i_bready) begin
			bvalid_next = 1'b0;
		end
		// one write at a time: hold both channels until the response
		awready_next = !aw_have_next && !bvalid_next;
		wready_next  = !w_have_next && !bvalid_next;
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			awready_reg <= 1'b0;
			wready_reg  <= 1'b0;
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			awaddr_reg  <= 8'h00;
			wdata_reg   <= 32'h0000_0000;
			wstrb_reg   <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
		end else begin
			awready_reg <= awready_next;
			wready_reg  <= wready_next;
			aw_have_reg <= aw_have_next;
			w_have_reg  <= w_have_next;
			awaddr_reg  <= awaddr_next;
			wdata_reg   <= wdata_next;
			wstrb_reg   <= wstrb_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
		end
	end

	// ----------------------------------------------------------------
	// data file port
	// ----------------------------------------------------------------
	assign w_eff = psi_eff(awaddr_reg, ptr_reg);
	// the indirect port is no storage: a write aimed at it is dropped
	assign mem_if.we    = do_write && !wr_err && awaddr_reg[7] &&
		wstrb_reg[0] && (w_eff != IND_PORT_ADDR);
	assign mem_if.waddr = w_eff;
	assign mem_if.wdata = wdata_reg[7:0];
	assign mem_if.raddr = psi_eff(i_araddr, ptr_reg);

	// ----------------------------------------------------------------
	// read channels
	// ----------------------------------------------------------------
	assign ar_fire = i_arvalid && arready_reg;

	always_comb begin
		rd_word = 32'h0000_0000;
		// misaligned window addresses answer an error with zero data
		if (raddr_reg[7] && psi_mapped(raddr_reg)) begin
			rd_word = rzero_reg ? 32'h0000_0000 :
				{24'h00_0000, mem_if.rdata};
		end else begin
			case (raddr_reg)
				OFF_EXEC: begin
					rd_word = {8'h00, result_reg, 4'h0, instr_reg};
				end
				OFF_PC: begin
					rd_word = {busy, 22'h00_0000, pc_reg};
				end
				OFF_ACC: begin
					rd_word = {24'h00_0000, acc_reg};
				end
				OFF_STATUS: begin
					rd_word = {25'h000_0000, page_reg, 5'h00};
				end
				OFF_POINTER: begin
					rd_word = {24'h00_0000, PTR_UNIMPL, ptr_reg};
				end
				OFF_STACK: begin
					rd_word = {20'h0_0000, stk_if.top};
				end
				default: begin
					rd_word = 32'h0000_0000;
				end
			endcase
		end
	end

	always_comb begin
		rpend_next  = rpend_reg;
		raddr_next  = raddr_reg;
		rzero_next  = rzero_reg;
		rvalid_next = rvalid_reg;
		rdata_next  = rdata_reg;
		rresp_next  = rresp_reg;
		if (ar_fire) begin
			rpend_next = 1'b1;
			raddr_next = i_araddr;
			rzero_next = (psi_eff(i_araddr, ptr_reg) == IND_PORT_ADDR);
		end
		// file data arrive one cycle after the address is taken
		if (rpend_reg) begin
			rpend_next  = 1'b0;
			rvalid_next = 1'b1;
			rdata_next  = rd_word;
			rresp_next  = psi_mapped(raddr_reg) ? RESP_OKAY : RESP_SLVERR;
		end
		if (rvalid_reg && i_rready) begin
			rvalid_next = 1'b0;
		end
		arready_next = !rpend_next && !rvalid_next;
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			arready_reg <= 1'b0;
			rpend_reg   <= 1'b0;
			raddr_reg   <= 8'h00;
			rzero_reg   <= 1'b0;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0000_0000;
			rresp_reg   <= RESP_OKAY;
		end else begin
			arready_reg <= arready_next;
			rpend_reg   <= rpend_next;
			raddr_reg   <= raddr_next;
			rzero_reg   <= rzero_next;
			rvalid_reg  <= rvalid_next;
			rdata_reg   <= rdata_next;
			rresp_reg   <= rresp_next;
		end
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	assign is_goto  = (instr_reg[11:9] == OPC_GOTO);
	assign is_call  = (instr_reg[11:8] == OPC_CALL);
	assign is_ret   = (instr_reg[11:8] == OPC_RETURN);
	// file-destination forms that land on the low counter byte
	assign is_low   = (instr_reg[4:0] == LOW_BYTE_ADDR) &&
		(((instr_reg[11:10] == OPC_FILE) && instr_reg[5]) ||
		(instr_reg[11:9] == OPC_BITOP));

	always_comb begin
		state_next       = state_reg;
		pc_next          = pc_reg;
		acc_next         = acc_reg;
		page_next        = page_reg;
		ptr_next         = ptr_reg;
		instr_next       = instr_reg;
		result_next      = result_reg;
		stk_if.push      = 1'b0;
		stk_if.pop       = 1'b0;
		stk_if.push_data = {3'h0, psi_pc_inc(pc_reg)};
		if (do_write && wstrb_reg[0]) begin
			if (awaddr_reg == OFF_ACC) begin
				acc_next = wdata_reg[7:0];
			end
			if (awaddr_reg == OFF_STATUS) begin
				page_next = wdata_reg[6:5];
			end
			if (awaddr_reg == OFF_POINTER) begin
				ptr_next = wdata_reg[4:0];
			end
		end
		case (state_reg)
			ST_IDLE: begin
				if (do_write && (awaddr_reg == OFF_EXEC)) begin
					if (wstrb_reg[0]) begin
						instr_next[7:0] = wdata_reg[7:0];
					end
					if (wstrb_reg[1]) begin
						instr_next[11:8] = wdata_reg[11:8];
					end
					if (wstrb_reg[2]) begin
						result_next = wdata_reg[23:16];
					end
					state_next = ST_EXEC;
				end
			end
			ST_EXEC: begin
				state_next = ST_IDLE;
				// 9-bit sum wraps 1FFh to 000h
				pc_next = psi_pc_inc(pc_reg);
				if (is_goto) begin
					pc_next    = instr_reg[8:0];
					state_next = ST_FLUSH;
				end else if (is_call) begin
					stk_if.push = 1'b1;
					pc_next     = {1'b0, instr_reg[7:0]};
					state_next  = ST_FLUSH;
				end else if (is_ret) begin
					stk_if.pop = 1'b1;
					pc_next    = stk_if.top[8:0];
					acc_next   = instr_reg[7:0];
					state_next = ST_FLUSH;
				end else if (is_low) begin
					pc_next    = {1'b0, result_reg};
					state_next = ST_FLUSH;
				end
			end
			ST_FLUSH: begin
				// prefetched word discarded, costs the extra cycle
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		// soft reset wins, and never touches the stack
		if (do_write && wstrb_reg[0] && (awaddr_reg == OFF_CTRL) &&
			wdata_reg[0]) begin
			pc_next     = PC_RESET;
			page_next   = PAGE_RESET;
			state_next  = ST_IDLE;
			stk_if.push = 1'b0;
			stk_if.pop  = 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg  <= ST_IDLE;
			pc_reg     <= PC_RESET;
			acc_reg    <= ACC_RESET;
			page_reg   <= PAGE_RESET;
			ptr_reg    <= PTR_RESET;
			instr_reg  <= INSTR_RESET;
			result_reg <= RES_RESET;
		end else begin
			state_reg  <= state_next;
			pc_reg     <= pc_next;
			acc_reg    <= acc_next;
			page_reg   <= page_next;
			ptr_reg    <= ptr_next;
			instr_reg  <= instr_next;
			result_reg <= result_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign o_awready = awready_reg;
	assign o_wready  = wready_reg;
	assign o_bvalid  = bvalid_reg;
	assign o_bresp   = bresp_reg;
	assign o_arready = arready_reg;
	assign o_rvalid  = rvalid_reg;
	assign o_rdata   = rdata_reg;
	assign o_rresp   = rresp_reg;

endmodule : psi_top

// file: logic/psi_pkg_end_marker_unused.sv
`timescale 1ns/1ps

// file: tb/psi_top_sva.sv
`timescale 1ns/1ps
module psi_top_sva import psi_pkg::*; (
	// clock and reset
	input wire logic        i_clk,
	input wire logic        i_rst_b,
	// write channels
	input wire logic        i_awvalid,
	input wire logic        o_awready,
	input wire logic [7:0]  i_awaddr,
	input wire logic        i_wvalid,
	input wire logic        o_wready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0]  i_wstrb,
	input wire logic        o_bvalid,
	input wire logic        i_bready,
	input wire logic [1:0]  o_bresp,
	// read channels
	input wire logic        i_arvalid,
	input wire logic        o_arready,
	input wire logic [7:0]  i_araddr,
	input wire logic        o_rvalid,
	input wire logic        i_rready,
	input wire logic [31:0] o_rdata,
	input wire logic [1:0]  o_rresp
);
	// ----------------------------------------------------------------
	// address trackers
	// ----------------------------------------------------------------
	logic [7:0] ar_reg;
	logic [7:0] ar_next;
	logic [7:0] aw_reg;
	logic [7:0] aw_next;
	logic       exec_reg;
	logic       exec_next;

	// exec flag: until an instruction runs the counter must sit at reset
	always_comb begin
		ar_next   = ar_reg;
		aw_next   = aw_reg;
		exec_next = exec_reg | (o_bvalid && aw_reg == OFF_EXEC);
		if (i_arvalid && o_arready) begin
			ar_next = i_araddr;
		end
		if (i_awvalid && o_awready) begin
			aw_next = i_awaddr;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ar_reg   <= 8'h00;
			aw_reg   <= 8'h00;
			exec_reg <= 1'b0;
		end else begin
			ar_reg   <= ar_next;
			aw_reg   <= aw_next;
			exec_reg <= exec_next;
		end
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	chk_wr_answer: assert property (o_awready && i_awvalid && o_wready
		&& i_wvalid |-> ##2 o_bvalid) else $error("write answer late");
	chk_wr_block: assert property (o_bvalid |-> !o_awready && !o_wready)
		else $error("write accepted while response pending");
	chk_wr_release: assert property (o_bvalid && i_bready
		|=> !o_bvalid && o_awready && o_wready)
		else $error("write response not released");
	chk_rd_answer: assert property (i_arvalid && o_arready |-> ##2 o_rvalid)
		else $error("read answer late");
	chk_rd_release: assert property (o_rvalid && i_rready
		|=> !o_rvalid && o_arready) else $error("read not released");
	chk_err_zero: assert property (o_rvalid && o_rresp == RESP_SLVERR
		|-> o_rdata == 32'h0000_0000) else $error("error read not zero");
	chk_ptr_ones: assert property (
		o_rvalid && ar_reg == OFF_POINTER |-> o_rdata[31:5] == 27'h7)
		else $error("pointer upper bits wrong");
	chk_stack_width: assert property (
		o_rvalid && ar_reg == OFF_STACK |-> o_rdata[31:12] == 20'h0)
		else $error("stack level wider than twelve bits");
	chk_pc_width: assert property (
		o_rvalid && ar_reg == OFF_PC |-> o_rdata[30:9] == 22'h0)
		else $error("counter wider than nine bits");
	chk_reset_vec: assert property (
		o_rvalid && ar_reg == OFF_PC && !exec_reg
		|-> o_rdata[8:0] == 9'h1FF) else $error("counter not at vector");
endmodule : psi_top_sva

bind psi_top psi_top_sva u_psi_top_sva (
	.i_clk(i_clk), .i_rst_b(i_rst_b), .i_awvalid(i_awvalid),
	.o_awready(o_awready), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid),
	.o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
	.o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
	.i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
	.o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
	.o_rresp(o_rresp)
);

// file: tb/psi_host_model.sv
`timescale 1ns/1ps
module psi_host_model (
	// clock
	input  wire logic        i_clk,
	// requests
	output      logic        o_awvalid,
	output      logic [7:0]  o_awaddr,
	output      logic        o_wvalid,
	output      logic [31:0] o_wdata,
	output      logic [3:0]  o_wstrb,
	output      logic        o_bready,
	output      logic        o_arvalid,
	output      logic [7:0]  o_araddr,
	output      logic        o_rready,
	// answers
	input  wire logic        i_awready,
	input  wire logic        i_wready,
	input  wire logic        i_bvalid,
	input  wire logic [1:0]  i_bresp,
	input  wire logic        i_arready,
	input  wire logic        i_rvalid,
	input  wire logic [31:0] i_rdata,
	input  wire logic [1:0]  i_rresp
);
	initial begin
		{o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h00;
		{o_awaddr, o_araddr, o_wstrb} = 20'h00000;
		o_wdata = 32'h0000_0000;
	end

	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r, output logic tmo);
		int n;
		tmo = 1'b1;
		r   = 2'h0;
		n   = 0;
		@(posedge i_clk);
		o_awvalid <= 1'b1;
		o_awaddr  <= a;
		o_wvalid  <= 1'b1;
		o_wdata   <= d;
		o_wstrb   <= 4'hF;
		o_bready  <= 1'b1;
		while (tmo && n < 100) begin
			@(posedge i_clk);
			n++;
			if (o_awvalid && i_awready) begin
				o_awvalid <= 1'b0;
			end
			if (o_wvalid && i_wready) begin
				o_wvalid <= 1'b0;
			end
			if (o_bready && i_bvalid) begin
				o_bready <= 1'b0;
				r = i_bresp;
				tmo = 1'b0;
			end
		end
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r, output logic tmo);
		int n;
		tmo = 1'b1;
		d   = 32'h0000_0000;
		r   = 2'h0;
		n   = 0;
		@(posedge i_clk);
		o_arvalid <= 1'b1;
		o_araddr  <= a;
		o_rready  <= 1'b1;
		while (tmo && n < 100) begin
			@(posedge i_clk);
			n++;
			if (o_arvalid && i_arready) begin
				o_arvalid <= 1'b0;
			end
			if (o_rready && i_rvalid) begin
				o_rready <= 1'b0;
				d = i_rdata;
				r = i_rresp;
				tmo = 1'b0;
			end
		end
	endtask : rd
endmodule : psi_host_model

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench import psi_pkg::*;;
	logic        i_clk = 1'b0;
	logic        i_rst_b = 1'b0;
	logic        i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid;
	logic        i_bready, i_arvalid, o_arready, o_rvalid, i_rready;
	logic [7:0]  i_awaddr, i_araddr;
	logic [31:0] i_wdata, o_rdata;
	logic [3:0]  i_wstrb;
	logic [1:0]  o_bresp, o_rresp;
	int          fails = 0;
	int          samples_checked = 0;
	logic [11:0] ops [3] = '{12'h022, 12'h5A2, 12'h1E2};
	logic [7:0]  res [3] = '{8'hC5, 8'h25, 8'h7E};

	always #25 i_clk = ~i_clk;

	psi_top u_psi_top (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr),
		.i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata),
		.i_wstrb(i_wstrb), .o_bvalid(o_bvalid), .i_bready(i_bready),
		.o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready),
		.i_araddr(i_araddr), .o_rvalid(o_rvalid), .i_rready(i_rready),
		.o_rdata(o_rdata), .o_rresp(o_rresp));

	psi_host_model u_psi_host_model (.i_clk(i_clk),
		.o_awvalid(i_awvalid), .o_awaddr(i_awaddr), .o_wvalid(i_wvalid),
		.o_wdata(i_wdata), .o_wstrb(i_wstrb), .o_bready(i_bready),
		.o_arvalid(i_arvalid), .o_araddr(i_araddr), .o_rready(i_rready),
		.i_awready(o_awready), .i_wready(o_wready), .i_bvalid(o_bvalid),
		.i_bresp(o_bresp), .i_arready(o_arready), .i_rvalid(o_rvalid),
		.i_rdata(o_rdata), .i_rresp(o_rresp));

	// ----------------------------------------------------------------
	// checking and bus helpers
	// ----------------------------------------------------------------
	task automatic report_and_stop;
		if (fails == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic hang(input logic tmo);
		if (tmo) begin
			fails++;
			report_and_stop;
		end
	endtask : hang

	task automatic wchk(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic [1:0] r;
		logic       t;
		u_psi_host_model.wr(a, d, r, t);
		hang(t);
		chk("write response", {30'h0, er}, {30'h0, r});
	endtask : wchk

	task automatic rchk(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		logic        t;
		u_psi_host_model.rd(a, d, r, t);
		hang(t);
		chk("read data", e, d);
		chk("read response", {30'h0, er}, {30'h0, r});
	endtask : rchk

	// poll busy, then compare the counter
	task automatic exec(input logic [11:0] ins, input logic [7:0] rb,
		input logic [8:0] pc);
		logic [31:0] d;
		logic [1:0]  r;
		logic        t;
		int          n;
		wchk(OFF_EXEC, {8'h00, rb, 4'h0, ins}, RESP_OKAY);
		d = 32'h8000_0000;
		n = 0;
		while (d[31] !== 1'b0 && n < 20) begin
			u_psi_host_model.rd(OFF_PC, d, r, t);
			hang(t);
			n++;
		end
		chk("program counter", {23'h0, pc}, d);
	endtask : exec

	task automatic pulse_reset;
		@(posedge i_clk);
		i_rst_b <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rst_b <= 1'b1;
		repeat (2) @(posedge i_clk);
	endtask : pulse_reset

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge i_clk);
		i_rst_b <= 1'b1;
		repeat (2) @(posedge i_clk);
		rchk(OFF_PC, 32'h1FF, RESP_OKAY);
		rchk(OFF_STATUS, 32'h0, RESP_OKAY);
		exec(12'h000, 8'h00, 9'h000);
		exec(12'h000, 8'h00, 9'h001);
		exec(12'hBAB, 8'h00, 9'h1AB);
		// five nested calls: the oldest return address falls off
		for (int i = 0; i < 5; i++) begin
			exec(12'h910 + 12'(i), 8'h00, 9'h010 + 9'(i));
		end
		rchk(OFF_STACK, 32'h014, RESP_OKAY);
		wchk(OFF_STATUS, 32'h60, RESP_OKAY);
		rchk(OFF_STATUS, 32'h60, RESP_OKAY);
		pulse_reset;
		rchk(OFF_PC, 32'h1FF, RESP_OKAY);
		rchk(OFF_STATUS, 32'h0, RESP_OKAY);
		rchk(OFF_STACK, 32'h014, RESP_OKAY);
		for (int i = 0; i < 5; i++) begin
			exec(12'h8A0 + 12'(i), 8'h00,
				(i == 4) ? 9'h011 : 9'h014 - 9'(i));
			rchk(OFF_ACC, 32'hA0 + 32'(i), RESP_OKAY);
		end
		// computed jumps start from the upper half to expose bit 8
		for (int i = 0; i < 3; i++) begin
			exec(12'hBF0, 8'h00, 9'h1F0);
			exec(ops[i], res[i], {1'b0, res[i]});
		end
		wchk(OFF_STATUS, 32'h60, RESP_OKAY);
		wchk(OFF_CTRL, 32'h1, RESP_OKAY);
		rchk(OFF_PC, 32'h1FF, RESP_OKAY);
		rchk(OFF_STATUS, 32'h0, RESP_OKAY);
		wchk(8'h94, 32'h10, RESP_OKAY);
		wchk(8'h98, 32'h0A, RESP_OKAY);
		wchk(OFF_POINTER, 32'h5, RESP_OKAY);
		rchk(OFF_WINDOW, 32'h10, RESP_OKAY);
		wchk(OFF_POINTER, 32'h6, RESP_OKAY);
		rchk(OFF_WINDOW, 32'h0A, RESP_OKAY);
		wchk(OFF_WINDOW, 32'h3C, RESP_OKAY);
		rchk(8'h98, 32'h3C, RESP_OKAY);
		wchk(OFF_POINTER, 32'h0, RESP_OKAY);
		rchk(OFF_WINDOW, 32'h0, RESP_OKAY);
		wchk(OFF_WINDOW, 32'h77, RESP_OKAY);
		rchk(8'h94, 32'h10, RESP_OKAY);
		rchk(8'h98, 32'h3C, RESP_OKAY);
		wchk(8'hFC, 32'h5A, RESP_OKAY);
		wchk(OFF_POINTER, 32'h7F, RESP_OKAY);
		rchk(OFF_POINTER, 32'hFF, RESP_OKAY);
		rchk(OFF_WINDOW, 32'h5A, RESP_OKAY);
		rchk(8'h1C, 32'h0, RESP_SLVERR);
		wchk(8'h1C, 32'h1, RESP_SLVERR);
		rchk(8'h05, 32'h0, RESP_SLVERR);
		rchk(8'h81, 32'h0, RESP_SLVERR);
		wchk(8'hFD, 32'h11, RESP_SLVERR);
		rchk(8'hFC, 32'h5A, RESP_OKAY);
		report_and_stop;
	end
endmodule : testbench
